/* tb_vpme_engine.sv */
// Self-checking bench for the pixel microcode engine
`timescale 1ns/10ps
`include "vpme_defs.vh"
module tb_vpme_engine;
reg sys_clk = 0, nrst = 0, drawing = 0, stall = 1;
reg [7:0] pixel_width = 8'h06;
reg [43:0] microcode = 44'h0;
wire [15:0] pat = 16'hA55A;
wire [15:0] fb_data;
wire fb_valid, fb_ready, pixel_strobe, underrun;
wire [7:0] coef_y;
wire [5:0] coef_a, coef_b;
reg [19:0] keep;
integer fail_count = 0, n_tests = 0, i;
vpme_engine vpme_engine_i (.sys_clk, .nrst, .drawing, .pixel_width, .microcode, .fb_data,
   .fb_valid, .fb_ready, .coef_y, .coef_a, .coef_b, .pixel_strobe, .underrun);
vpme_fb_model vpme_fb_model_i (.sys_clk, .stall, .pat, .fb_ready, .fb_data, .fb_valid);
function [10:0] st(input [1:0] t, input [3:0] tk, input [3:0] sh);
   st = (t << `VPME_STEP_TGT_LSB) | (tk << `VPME_STEP_TAKE_LSB) | sh;
endfunction
task chk(input string nm, input [19:0] exp, input [19:0] got);
   n_tests = n_tests + 1;
   if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
   end
endtask
task pix;
   @(posedge sys_clk) #1;
   for (i = 0; i < 60 && pixel_strobe !== 1'b1; i++) @(posedge sys_clk) #1;
   chk("pixel_strobe", 1, pixel_strobe);
endtask
task t_refuse;
   stall = 0;
   repeat (30) @(posedge sys_clk) #1;
   chk("fb_ready", 0, fb_ready);
endtask
task t_chroma;
   microcode = {st(`VPME_TGT_N, 1, 0), st(`VPME_TGT_Y, 3, 3), st(`VPME_TGT_A, 6, 3),
      st(`VPME_TGT_B, 6, 2)};
   drawing = 1;
   repeat (4) begin
      pix;
      if (coef_b === 6'h29) chk("a y", {6'h25, 8'h05}, {coef_a, coef_y});
      else chk("b a y", {6'h16, 6'h1A, 8'h02}, {coef_b, coef_a, coef_y});
   end
endtask
task t_luma;
   microcode = {{3{st(`VPME_TGT_N, 0, 0)}}, st(`VPME_TGT_Y, 8, 8)};
   pix;
   pix;
   keep = coef_y;
   repeat (3) begin
      pix;
      chk("coef_y", keep[7:0] ^ 8'hFF, coef_y);
      keep = coef_y;
   end
endtask
task t_nop;
   microcode = {4{st(`VPME_TGT_N, 1, 0)}};
   pix;
   pix;
   keep = {coef_b, coef_a, coef_y};
   repeat (3) pix;
   chk("coefs", keep, {coef_b, coef_a, coef_y});
endtask
task t_underrun;
   stall = 1;
   microcode = {{3{st(`VPME_TGT_N, 0, 0)}}, st(`VPME_TGT_Y, 8, 8)};
   for (i = 0; i < 600 && underrun !== 1'b1; i++) @(posedge sys_clk) #1;
   chk("underrun", 1, underrun);
   drawing = 0;
   stall = 0;
endtask
task test_done;
   $display("tests %0d failures %0d", n_tests, fail_count);
   if (fail_count == 0 && n_tests > 0) $display("verification passed");
   else $display("verification failed");
   $finish;
endtask
initial forever #20 sys_clk = ~sys_clk;
initial begin
   repeat (5) @(posedge sys_clk);
   #1 nrst = 1;
   t_refuse;
   t_chroma;
   t_luma;
   t_nop;
   t_underrun;
   test_done;
end
initial begin
   #100000;
   fail_count = fail_count + 1;
   test_done;
end
endmodule // tb_vpme_engine

/* vpme_defs.vh */
// Constants for the video pixel microcode engine
// What this block does
// RQ1: While drawing, fetch frame buffer pixel words into an internal shift register.
// RQ2: Take shift register bits into luminance Y and chroma A and B coefficients.
// RQ3: Bits taken and bits shifted out are set separately per step.
// RQ4: Each step encodes target coefficient, bits to take, bits to shift.
// RQ5: No-coefficient step changes no output; zero shift leaves register unchanged; the code can still raise underrun on a no-coefficient step.
// RQ6: Run exactly four steps per pixel, then no-ops until pixel width elapses.
// RQ7: Coefficients hold up to 8 bits luminance and 6 bits per chroma.
// RQ8: A and B are the modulator's two chroma axes, meaning set by burst phase.
// RQ9: Reload the shift register before a step needs more bits than remain; the code reloads once under 16 bits are left, in the step's own cycle.
`ifndef VPME_DEFS_VH
`define VPME_DEFS_VH
`define VPME_TGT_N 2'h0
`define VPME_TGT_Y 2'h1
`define VPME_TGT_A 2'h2
`define VPME_TGT_B 2'h3
`define VPME_STEP_TGT_LSB 8
`define VPME_STEP_TAKE_LSB 4
`define VPME_STEP_SHIFT_LSB 0
`define VPME_STEPS 4
`define VPME_Y_W 8
`define VPME_C_W 6
`define VPME_PIXW_RST 8'h04
`define VPME_Y_RST 8'h00
`define VPME_C_RST 6'h00
`endif

/* vpme_engine.v */
// Pixel microcode engine: shift register, four-step program, coefficient outputs
`timescale 1ns/10ps
`include "vpme_defs.vh"
module vpme_engine #(
   parameter WORD_W = 16,
   parameter FIFO_DEPTH = 8,
   parameter FIFO_AW = 3
) (
   input wire sys_clk,
   input wire nrst,
   input wire drawing,
   input wire [7:0] pixel_width,
   input wire [43:0] microcode,
   input wire [WORD_W-1:0] fb_data,
   input wire fb_valid,
   output wire fb_ready,
   output reg [`VPME_Y_W-1:0] coef_y,
   output reg [`VPME_C_W-1:0] coef_a,
   output reg [`VPME_C_W-1:0] coef_b,
   output reg pixel_strobe,
   output reg underrun
);
   // Microcode: four 11-bit steps, step 0 in bits 10:0; each is tgt[1:0] take[3:0] shift[3:0]
   localparam SR_W = 2 * WORD_W;
   localparam CW = 6;
   localparam ST_IDLE = 3'b001;
   localparam ST_STEP = 3'b010;
   localparam ST_NOP = 3'b100;

   reg [2:0] state_q;
   reg [1:0] step_q;
   reg [7:0] cyc_q;
   reg [SR_W-1:0] sr_q;
   reg [CW-1:0] avail_q;
   wire [WORD_W-1:0] w_data;
   wire w_valid;
   wire w_ready;
   reg [10:0] cur;
   reg [1:0] tgt;
   reg [3:0] take;
   reg [3:0] shn;
   reg [7:0] taken;
   reg need_load;
   reg [SR_W-1:0] sr_fill;
   reg [CW-1:0] av_fill;

   vpme_fifo #(
      .WIDTH(WORD_W),
      .DEPTH(FIFO_DEPTH),
      .AW(FIFO_AW)
   ) u_fifo (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .in_data(fb_data),
      .in_valid(fb_valid),
      .in_ready(fb_ready),
      .out_data(w_data),
      .out_valid(w_valid),
      .out_ready(w_ready)
   );

   // Step decode and refill; bits are consumed from the MSB end
   always @* begin
      cur = microcode[11*step_q +: 11]; // [RQ4]
      tgt = cur[`VPME_STEP_TGT_LSB +: 2];
      take = cur[`VPME_STEP_TAKE_LSB +: 4];
      shn = cur[`VPME_STEP_SHIFT_LSB +: 4]; // [RQ3]
      // A take count above eight acts as eight
      taken = sr_q[SR_W-1 -: 8] >> ((take > 4'd8) ? 4'd0 : (4'd8 - take));
      // Refill when the current word may not cover the next step [RQ9]
      need_load = (avail_q < WORD_W[CW-1:0]) && w_valid && drawing;
      sr_fill = sr_q;
      av_fill = avail_q;
      if (need_load) begin
         sr_fill = sr_q | ({{WORD_W{1'b0}}, w_data} << (SR_W[CW-1:0] - WORD_W[CW-1:0] - avail_q));
         av_fill = avail_q + WORD_W[CW-1:0];
      end
   end
   assign w_ready = need_load; // [RQ1]

   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         state_q <= ST_IDLE;
         step_q <= 2'h0;
         cyc_q <= 8'h00;
         sr_q <= {SR_W{1'b0}};
         avail_q <= {CW{1'b0}};
         coef_y <= `VPME_Y_RST;
         coef_a <= `VPME_C_RST;
         coef_b <= `VPME_C_RST;
         pixel_strobe <= 1'b0;
         underrun <= 1'b0;
      end else begin
         pixel_strobe <= 1'b0;
         underrun <= 1'b0;
         sr_q <= sr_fill;
         avail_q <= av_fill;
         case (state_q)
            ST_IDLE: begin
               step_q <= 2'h0;
               cyc_q <= 8'h00;
               if (drawing) begin
                  state_q <= ST_STEP;
               end
            end
            ST_STEP: begin
               if (avail_q < {2'b00, take} || avail_q < {2'b00, shn}) begin
                  underrun <= 1'b1;
               end
               case (tgt) // [RQ2] [RQ8]
                  `VPME_TGT_Y: coef_y <= taken; // [RQ7]
                  `VPME_TGT_A: coef_a <= taken[`VPME_C_W-1:0];
                  `VPME_TGT_B: coef_b <= taken[`VPME_C_W-1:0];
                  default: begin
                  end // [RQ5]
               endcase
               if (shn != 4'h0) begin
                  sr_q <= sr_fill << shn; // [RQ5]
                  avail_q <= (av_fill > {2'b00, shn}) ? av_fill - {2'b00, shn} : {CW{1'b0}};
               end
               cyc_q <= cyc_q + 8'h01;
               step_q <= step_q + 2'h1;
               if (step_q == 2'd3) begin // [RQ6]
                  if (cyc_q + 8'h01 >= pixel_width) begin
                     pixel_strobe <= 1'b1;
                     cyc_q <= 8'h00;
                     state_q <= drawing ? ST_STEP : ST_IDLE;
                  end else begin
                     state_q <= ST_NOP;
                  end
               end
            end
            ST_NOP: begin
               cyc_q <= cyc_q + 8'h01;
               if (cyc_q + 8'h01 >= pixel_width) begin // [RQ6]
                  pixel_strobe <= 1'b1;
                  cyc_q <= 8'h00;
                  step_q <= 2'h0;
                  state_q <= drawing ? ST_STEP : ST_IDLE;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end
endmodule // vpme_engine

/* vpme_engine_sva.sv */
// Port assertions for the pixel microcode engine
`timescale 1ns/10ps
`include "vpme_defs.vh"
module vpme_chk (
   input wire sys_clk,
   input wire nrst,
   input wire drawing,
   input wire [7:0] pixel_width,
   input wire [43:0] microcode,
   input wire fb_ready,
   input wire [`VPME_Y_W-1:0] coef_y,
   input wire [`VPME_C_W-1:0] coef_a,
   input wire [`VPME_C_W-1:0] coef_b,
   input wire pixel_strobe,
   input wire underrun
);
default clocking @(posedge sys_clk); endclocking
default disable iff (!nrst);
reg [7:0] cnt_q;
reg seen_q;
function automatic hit(input [1:0] t);
   hit = 1'b0;
   for (int k = 0; k < 4; k++) if (microcode[11*k+`VPME_STEP_TGT_LSB+:2] == t) hit = 1'b1;
endfunction
// Cycles since the last pixel end, valid only while drawing stayed high
always @(posedge sys_clk or negedge nrst) begin
   if (!nrst) begin
      cnt_q <= 8'h00;
      seen_q <= 1'b0;
   end else begin
      cnt_q <= pixel_strobe ? 8'h01 : cnt_q + 8'h01;
      seen_q <= (seen_q | pixel_strobe) & drawing;
   end
end
a_strobe_one: assert property (pixel_strobe |=> !pixel_strobe)
   else $error("pixel strobe longer than one cycle");
a_pixel_period: assert property (pixel_strobe && seen_q && $stable(pixel_width)
   && pixel_width > 8'h03 |-> cnt_q == pixel_width) else $error("pixel period wrong");
a_y_hold: assert property (!hit(`VPME_TGT_Y) [*8] |=> $stable(coef_y))
   else $error("luma changed without a luma step");
a_a_hold: assert property (!hit(`VPME_TGT_A) [*8] |=> $stable(coef_a))
   else $error("chroma A changed without an A step");
a_b_hold: assert property (!hit(`VPME_TGT_B) [*8] |=> $stable(coef_b))
   else $error("chroma B changed without a B step");
a_rst_coef: assert property ($rose(nrst) |-> coef_y == 0 && coef_a == 0 && coef_b == 0)
   else $error("coefficients not cleared by reset");
a_rst_ready: assert property ($rose(nrst) |-> fb_ready && !pixel_strobe && !underrun)
   else $error("fetch port state after reset wrong");
a_idle_still: assert property ((!drawing && pixel_width < 8'h07) [*8] |-> !pixel_strobe)
   else $error("pixel ended while not drawing");
cover property (pixel_strobe);
cover property (underrun);
cover property (!fb_ready);
endmodule // vpme_chk
bind vpme_engine vpme_chk vpme_chk_i (.sys_clk, .nrst, .drawing, .pixel_width, .microcode,
   .fb_ready, .coef_y, .coef_a, .coef_b, .pixel_strobe, .underrun);

/* vpme_fb_model.sv */
// Frame buffer word source feeding the engine's fetch port
`timescale 1ns/10ps
module vpme_fb_model (
   input wire sys_clk,
   input wire stall,
   input wire [15:0] pat,
   input wire fb_ready,
   output reg [15:0] fb_data,
   output reg fb_valid
);
reg rdy;
initial fb_valid = 1'b0;
initial fb_data = 16'h0000;
always @(negedge sys_clk) rdy = fb_ready;
// A word stays offered until taken; idle data is inverted so it never looks valid
always @(posedge sys_clk) begin
   #1;
   if (!fb_valid || rdy) begin
      fb_valid = !stall;
      fb_data = stall ? ~pat : pat;
   end
end
endmodule // vpme_fb_model

/* vpme_fifo.v */
// Word FIFO between frame buffer fetch and the microcode engine
`timescale 1ns/10ps
module vpme_fifo #(
   parameter WIDTH = 16,
   parameter DEPTH = 8,
   parameter AW = 3
) (
   input wire sys_clk,
   input wire nrst,
   input wire [WIDTH-1:0] in_data,
   input wire in_valid,
   output wire in_ready,
   output wire [WIDTH-1:0] out_data,
   output wire out_valid,
   input wire out_ready
);
   reg [WIDTH-1:0] mem_q [0:DEPTH-1];
   reg [AW-1:0] wp_q;
   reg [AW-1:0] rp_q;
   reg [AW:0] cnt_q;
   wire push;
   wire pop;
   assign in_ready = (cnt_q != DEPTH[AW:0]);
   assign out_valid = (cnt_q != {(AW+1){1'b0}});
   assign out_data = mem_q[rp_q];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   always @(posedge sys_clk) begin
      if (push) begin
         mem_q[wp_q] <= in_data;
      end
   end
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         wp_q <= {AW{1'b0}};
         rp_q <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wp_q <= (wp_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_q + 1'b1;
         end
         if (pop) begin
            rp_q <= (rp_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_q + 1'b1;
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop && !push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule // vpme_fifo
